// >>> src/smpb_bank.sv
// smpb_bank: wishbone slave holding the checked second-motor parameter registers
//
// Added by the designer: register access over Wishbone.
`default_nettype none
module smpb_bank (
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire smpb_pkg::smpb_wb_req_t wb_req,
    output var  smpb_pkg::smpb_wb_rsp_t wb_rsp,
    output var  smpb_pkg::smpb_params_t params
);
    import smpb_pkg::*;

    // ****************************************
    // stored values
    // ****************************************
    logic [31:0] accel_time;
    logic [31:0] decel_time;
    logic [31:0] accel_freq;
    logic [31:0] decel_freq;
    logic [15:0] ramp_sw;
    logic [15:0] th_level;
    logic [15:0] th_curve;
    logic [15:0] ol_mode;
    logic [15:0] ol_level;
    logic [15:0] ol_decel;
    logic [15:0] ol_warn;
    logic [15:0] md_src;
    logic [15:0] m_cap;
    logic        ext_range;
    logic [15:0] pend_hi;
    logic        pend_valid;
    logic [15:0] pend_idx;
    logic        st_reject;
    logic        st_reserved;
    logic        ack_q;
    logic        err_q;
    logic [31:0] rdat_q;

    // ****************************************
    // decode
    // ****************************************
    logic        req;
    logic        full_wr;
    logic [15:0] idx;
    logic [15:0] wval;
    logic [31:0] wide;
    logic        mapped;
    logic        in_range;
    logic        is_hi;
    logic        is_lo;
    logic [31:0] frq_max;
    logic [31:0] next_rdat;

    assign req     = wb_req.cyc && wb_req.stb && !ack_q && !err_q;
    assign idx     = wb_req.adr[ADDR_LSB+15:ADDR_LSB];
    assign wval    = wb_req.dat[15:0];
    assign full_wr = wb_req.sel[1:0] == 2'b11;
    assign wide    = {pend_hi, wval};
    assign frq_max = ext_range ? FRQ_MAX_EXT : FRQ_MAX_STD;
    assign is_hi   = idx == IDX_SECOND_ACCEL_RAMP_HI || idx == IDX_SECOND_DECEL_RAMP_HI || idx == IDX_AFRQ_HI || idx == IDX_DFRQ_HI;
    assign is_lo   = idx == IDX_SECOND_ACCEL_RAMP_LO || idx == IDX_SECOND_DECEL_RAMP_LO || idx == IDX_AFRQ_LO || idx == IDX_DFRQ_LO;

    // high index of the pair that a low index belongs to
    function automatic logic [15:0] pair_hi(input logic [15:0] i);
        pair_hi = i - 16'h0001;
    endfunction

    always_comb begin
        mapped = 1'b1;
        case (idx)
            IDX_SECOND_ACCEL_RAMP_HI, IDX_SECOND_ACCEL_RAMP_LO, IDX_SECOND_DECEL_RAMP_HI, IDX_SECOND_DECEL_RAMP_LO, IDX_RSW,
            IDX_AFRQ_HI, IDX_AFRQ_LO, IDX_DFRQ_HI, IDX_DFRQ_LO, IDX_THLV,
            IDX_THCV, IDX_OLMD, IDX_OLLV, IDX_OLDR, IDX_OLW2, IDX_MDSRC,
            IDX_MCAP, IDX_CTRL, IDX_STAT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        if (wb_req.adr[31:ADDR_LSB+16] != '0) begin
            mapped = 1'b0;
        end
    end

    // range check of a write against its target
    always_comb begin
        in_range = 1'b1;
        case (idx)
            IDX_SECOND_ACCEL_RAMP_LO, IDX_SECOND_DECEL_RAMP_LO: in_range = wide >= TIME2_MIN && wide <= TIME2_MAX;
            IDX_AFRQ_LO, IDX_DFRQ_LO: in_range = wide <= frq_max;
            IDX_RSW:   in_range = wval <= RSW_MAX;
            IDX_THLV:  in_range = wval >= THLV_MIN && wval <= THLV_MAX;
            IDX_THCV:  in_range = wval <= THCV_MAX;
            IDX_OLMD:  in_range = wval <= OLMD_MAX;
            IDX_OLLV:  in_range = wval >= OLLV_MIN && wval <= OLLV_MAX;
            IDX_OLDR:  in_range = wval >= OLDR_MIN && wval <= OLDR_MAX;
            IDX_OLW2:  in_range = wval <= OLW2_MAX;
            IDX_MDSRC: in_range = wval == MDSRC_STD || wval == MDSRC_AUTO;
            IDX_MCAP:  in_range = wval <= MCAP_MAX;
            default:   in_range = 1'b1;
        endcase
        // a low half is refused unless the upper half of its own pair was the last write
        if (is_lo && !(pend_valid && pend_idx == pair_hi(idx))) begin
            in_range = 1'b0;
        end
        if (!full_wr) begin
            in_range = 1'b0;
        end
    end

    logic wr_ok;
    logic wr_bad;
    assign wr_ok  = req && wb_req.we && mapped && in_range;
    assign wr_bad = req && (!mapped || (wb_req.we && !in_range));

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        next_rdat = 32'h0000_0000;
        case (idx)
            IDX_SECOND_ACCEL_RAMP_HI: next_rdat[15:0] = accel_time[31:16];
            IDX_SECOND_ACCEL_RAMP_LO: next_rdat[15:0] = accel_time[15:0];
            IDX_SECOND_DECEL_RAMP_HI: next_rdat[15:0] = decel_time[31:16];
            IDX_SECOND_DECEL_RAMP_LO: next_rdat[15:0] = decel_time[15:0];
            IDX_RSW:     next_rdat[15:0] = ramp_sw;
            IDX_AFRQ_HI: next_rdat[15:0] = accel_freq[31:16];
            IDX_AFRQ_LO: next_rdat[15:0] = accel_freq[15:0];
            IDX_DFRQ_HI: next_rdat[15:0] = decel_freq[31:16];
            IDX_DFRQ_LO: next_rdat[15:0] = decel_freq[15:0];
            IDX_THLV:    next_rdat[15:0] = th_level;
            IDX_THCV:    next_rdat[15:0] = th_curve;
            IDX_OLMD:    next_rdat[15:0] = ol_mode;
            IDX_OLLV:    next_rdat[15:0] = ol_level;
            IDX_OLDR:    next_rdat[15:0] = ol_decel;
            IDX_OLW2:    next_rdat[15:0] = ol_warn;
            IDX_MDSRC:   next_rdat[15:0] = md_src;
            IDX_MCAP:    next_rdat[15:0] = m_cap;
            IDX_CTRL:    next_rdat[CTRL_EXT_BIT] = ext_range;
            IDX_STAT: begin
                next_rdat[STAT_REJ_BIT]  = st_reject;
                next_rdat[STAT_RSV_BIT]  = st_reserved;
                next_rdat[STAT_PEND_BIT] = pend_valid;
            end
            default:     next_rdat = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // bus answer: one wait state, ack or err, dropped the next cycle
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack_q  <= 1'b0;
            err_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= req && !wr_bad;
            err_q  <= wr_bad;
            rdat_q <= (req && !wb_req.we && mapped) ? next_rdat : 32'h0000_0000;
        end
    end

    assign wb_rsp.ack = ack_q;
    assign wb_rsp.err = err_q;
    assign wb_rsp.dat = rdat_q;

    // ****************************************
    // upper-half latch for two-word values
    // ****************************************
    // the upper half is held aside so a half-written pair never reaches the motor logic
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pend_hi    <= 16'h0000;
            pend_idx   <= 16'h0000;
            pend_valid <= 1'b0;
        end else if (req && wb_req.we) begin
            if (is_hi && mapped && full_wr) begin
                pend_hi    <= wval;
                pend_idx   <= idx;
                pend_valid <= 1'b1;
            end else begin
                pend_valid <= 1'b0;
            end
        end
    end

    // ****************************************
    // parameter storage
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            accel_time <= RST_TIME2;
            decel_time <= RST_TIME2;
            accel_freq <= RST_FRQ;
            decel_freq <= RST_FRQ;
            ramp_sw    <= RST_ZERO;
            th_level   <= RST_THLV;
            th_curve   <= RST_ZERO;
            ol_mode    <= RST_ZERO;
            ol_level   <= RST_OLLV;
            ol_decel   <= RST_OLDR;
            ol_warn    <= RST_OLW2;
            md_src     <= RST_ZERO;
            m_cap      <= RST_ZERO;
            ext_range  <= 1'b0;
        end else if (wr_ok) begin
            // low-half writes commit only if the pending upper half belongs to the same pair
            case (idx)
                IDX_SECOND_ACCEL_RAMP_LO: if (pend_idx == IDX_SECOND_ACCEL_RAMP_HI) accel_time <= wide;
                IDX_SECOND_DECEL_RAMP_LO: if (pend_idx == IDX_SECOND_DECEL_RAMP_HI) decel_time <= wide;
                IDX_AFRQ_LO: if (pend_idx == IDX_AFRQ_HI) accel_freq <= wide;
                IDX_DFRQ_LO: if (pend_idx == IDX_DFRQ_HI) decel_freq <= wide;
                IDX_RSW:     ramp_sw  <= wval;
                IDX_THLV:    th_level <= wval;
                IDX_THCV:    th_curve <= wval;
                IDX_OLMD:    ol_mode  <= wval;
                IDX_OLLV:    ol_level <= wval;
                IDX_OLDR:    ol_decel <= wval;
                IDX_OLW2:    ol_warn  <= wval;
                IDX_MDSRC:   md_src   <= wval;
                IDX_MCAP:    m_cap    <= wval;
                IDX_CTRL:    ext_range <= wval[CTRL_EXT_BIT];
                default:     ;
            endcase
        end
    end

    // sticky status, cleared by writing a one; a new event in the same cycle wins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_reject   <= 1'b0;
            st_reserved <= 1'b0;
        end else begin
            if (req && wb_req.we && idx == IDX_STAT && mapped && full_wr) begin
                if (wval[STAT_REJ_BIT]) st_reject <= 1'b0;
                if (wval[STAT_RSV_BIT]) st_reserved <= 1'b0;
            end
            if (req && mapped && wb_req.we && !in_range) st_reject <= 1'b1;
            if (req && !mapped) st_reserved <= 1'b1;
        end
    end

    // ****************************************
    // decoded parameter outputs
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            params <= '0;
        end else begin
            params.accel_time       <= accel_time;
            params.decel_time       <= decel_time;
            params.ramp_sel         <= smpb_ramp_t'(ramp_sw[1:0]);
            params.accel_freq       <= accel_freq;
            params.decel_freq       <= decel_freq;
            params.thermal_level    <= th_level;
            params.thermal_curve    <= smpb_curve_t'(th_curve[1:0]);
            params.olim_enable      <= ol_mode != RST_ZERO;
            params.olim_accel       <= ol_mode[0];
            params.olim_regen_boost <= ol_mode == OLMD_MAX;
            params.olim_level       <= ol_level;
            params.olim_decel       <= ol_decel;
            params.warn_level       <= ol_warn;
            params.data_autotuned   <= md_src == MDSRC_AUTO;
            params.capacity         <= m_cap[3:0];
        end
    end

endmodule : smpb_bank
`default_nettype wire

// >>> src/smpb_pkg.sv
// smpb_pkg: register map, field limits and carrier types of the second-motor parameter bank
//
// What this block does
// - ramp switch method: 0 terminal input, 1 transition frequencies, 2 on reversal only.
// - accel transition frequency: unsigned 0..40000 (0.01 Hz), alternate range up to 100000.
// - decel transition frequency: unsigned 0..40000 (0.01 Hz), alternate range up to 100000.
// - wide values take two words: upper half at lower address, lower half next.
// - thermal level accepts 200..1000, count of 0.1 percent rated current.
// - thermal curve: 0 reduced torque, 1 constant torque, 2 free curve.
// - overload limit mode: 0 off, 1 accel+const, 2 const only, 3 accel+const raising speed.
// - overload limit level accepts 100..2000, count of 0.1 percent.
// - overload limit decel rate accepts 1..30000, count of 0.1 second.
// - second overload warning level accepts 0..2000, count of 0.1 percent.
// - motor data source: 0 standard constants, 2 auto-tuned; nothing else defined.
// - motor capacity index 0..15 selects rated motor size.
`default_nettype none
package smpb_pkg;

    // ****************************************
    // register word indices; byte address is four times the index
    // ****************************************
    localparam logic [15:0] IDX_SECOND_ACCEL_RAMP_HI   = 16'h226F;
    localparam logic [15:0] IDX_SECOND_ACCEL_RAMP_LO   = 16'h2270;
    localparam logic [15:0] IDX_SECOND_DECEL_RAMP_HI   = 16'h2271;
    localparam logic [15:0] IDX_SECOND_DECEL_RAMP_LO   = 16'h2272;
    localparam logic [15:0] IDX_RSW       = 16'h2273;
    localparam logic [15:0] IDX_AFRQ_HI   = 16'h2274;
    localparam logic [15:0] IDX_AFRQ_LO   = 16'h2275;
    localparam logic [15:0] IDX_DFRQ_HI   = 16'h2276;
    localparam logic [15:0] IDX_DFRQ_LO   = 16'h2277;
    localparam logic [15:0] IDX_THLV      = 16'h230C;
    localparam logic [15:0] IDX_THCV      = 16'h230D;
    localparam logic [15:0] IDX_OLMD      = 16'h2316;
    localparam logic [15:0] IDX_OLLV      = 16'h2317;
    localparam logic [15:0] IDX_OLDR      = 16'h2318;
    localparam logic [15:0] IDX_OLW2      = 16'h2429;
    localparam logic [15:0] IDX_MDSRC     = 16'h2502;
    localparam logic [15:0] IDX_MCAP      = 16'h2503;
    localparam logic [15:0] IDX_CTRL      = 16'h2600;
    localparam logic [15:0] IDX_STAT      = 16'h2601;
    localparam int          ADDR_LSB      = 2;

    // ****************************************
    // value limits
    // ****************************************
    localparam logic [31:0] TIME2_MIN     = 32'h0000_0001;
    localparam logic [31:0] TIME2_MAX     = 32'h0005_7E40;  // 360000
    localparam logic [31:0] FRQ_MAX_STD   = 32'h0000_9C40;  // 40000
    localparam logic [31:0] FRQ_MAX_EXT   = 32'h0001_86A0;  // 100000
    localparam logic [15:0] RSW_MAX       = 16'h0002;
    localparam logic [15:0] THLV_MIN      = 16'h00C8;
    localparam logic [15:0] THLV_MAX      = 16'h03E8;
    localparam logic [15:0] THCV_MAX      = 16'h0002;
    localparam logic [15:0] OLMD_MAX      = 16'h0003;
    localparam logic [15:0] OLLV_MIN      = 16'h0064;
    localparam logic [15:0] OLLV_MAX      = 16'h07D0;
    localparam logic [15:0] OLDR_MIN      = 16'h0001;
    localparam logic [15:0] OLDR_MAX      = 16'h7530;
    localparam logic [15:0] OLW2_MAX      = 16'h07D0;
    localparam logic [15:0] MDSRC_STD     = 16'h0000;
    localparam logic [15:0] MDSRC_AUTO    = 16'h0002;
    localparam logic [15:0] MCAP_MAX      = 16'h000F;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [31:0] RST_TIME2     = 32'h0000_03E8;
    localparam logic [31:0] RST_FRQ       = 32'h0000_0000;
    localparam logic [15:0] RST_THLV      = 16'h03E8;
    localparam logic [15:0] RST_OLLV      = 16'h05DC;
    localparam logic [15:0] RST_OLDR      = 16'h000A;
    localparam logic [15:0] RST_OLW2      = 16'h05DC;
    localparam logic [15:0] RST_ZERO      = 16'h0000;

    // ****************************************
    // control and status fields
    // ****************************************
    localparam int          CTRL_EXT_BIT  = 0;
    localparam int          STAT_REJ_BIT  = 0;
    localparam int          STAT_RSV_BIT  = 1;
    localparam int          STAT_PEND_BIT = 2;

    typedef enum logic [1:0] {
        SMPB_RAMP_TERMINAL,
        SMPB_RAMP_FREQ,
        SMPB_RAMP_REVERSE
    } smpb_ramp_t;

    typedef enum logic [1:0] {
        SMPB_CURVE_REDUCED,
        SMPB_CURVE_CONSTANT,
        SMPB_CURVE_FREE
    } smpb_curve_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [31:0] adr;
        logic [31:0] dat;
    } smpb_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] dat;
    } smpb_wb_rsp_t;

    typedef struct packed {
        logic [31:0] accel_time;
        logic [31:0] decel_time;
        smpb_ramp_t  ramp_sel;
        logic [31:0] accel_freq;
        logic [31:0] decel_freq;
        logic [15:0] thermal_level;
        smpb_curve_t thermal_curve;
        logic        olim_enable;
        logic        olim_accel;
        logic        olim_regen_boost;
        logic [15:0] olim_level;
        logic [15:0] olim_decel;
        logic [15:0] warn_level;
        logic        data_autotuned;
        logic [3:0]  capacity;
    } smpb_params_t;

endpackage : smpb_pkg
`default_nettype wire

// >>> dv/smpb_bank_props.sv
// smpb_bank_props: bus timing and parameter legality checker for the parameter bank
`default_nettype none
module smpb_bank_props (
    input wire smpb_pkg::smpb_wb_req_t wb_req,
    input wire smpb_pkg::smpb_wb_rsp_t wb_rsp,
    input wire smpb_pkg::smpb_params_t params,
    input wire logic                   sys_clk,
    input wire logic                   rst
);
    timeunit 1ns;
    timeprecision 1ps;
    import smpb_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ****************************************
    // request decode
    // ****************************************
    logic        taken;
    logic        mapped;
    logic [15:0] idx;
    assign idx    = wb_req.adr[17:2];
    assign taken  = wb_req.cyc && wb_req.stb && !wb_rsp.ack && !wb_rsp.err;
    assign mapped = (wb_req.adr[31:18] == 14'h0) && ((idx >= IDX_SECOND_ACCEL_RAMP_HI && idx <= IDX_DFRQ_LO) ||
        idx inside {IDX_THLV, IDX_THCV, IDX_OLMD, IDX_OLLV, IDX_OLDR, IDX_OLW2, IDX_MDSRC, IDX_MCAP, IDX_CTRL, IDX_STAT});

    // ****************************************
    // assertions
    // ****************************************
    a_answer_next: assert property (taken |=> (wb_rsp.ack || wb_rsp.err))
        else $error("request not answered in the next cycle");
    a_unmapped_err: assert property (taken && !mapped |=> wb_rsp.err && !wb_rsp.ack)
        else $error("unmapped access not refused");
    a_refused_keeps: assert property (wb_rsp.err |=> $stable(params))
        else $error("refused access changed a parameter");
    a_ack_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack && !wb_rsp.err)
        else $error("ack stood longer than one cycle");
    a_err_pulse: assert property (wb_rsp.err |-> !wb_rsp.ack ##1 !wb_rsp.err)
        else $error("err overlapped ack or stood too long");
    a_dat_quiet: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0)
        else $error("read data not zero outside ack");
    a_word_upper: assert property (wb_rsp.ack |-> wb_rsp.dat[31:16] == 16'h0)
        else $error("upper half of read word not zero");
    a_thermal_legal: assert property (!$past(rst) |-> params.thermal_level inside {[THLV_MIN:THLV_MAX]} &&
        params.thermal_curve <= SMPB_CURVE_FREE) else $error("thermal parameter out of range");
    a_olim_legal: assert property (!$past(rst) |-> params.olim_level inside {[OLLV_MIN:OLLV_MAX]} &&
        params.olim_decel inside {[OLDR_MIN:OLDR_MAX]} && params.warn_level <= OLW2_MAX)
        else $error("overload parameter out of range");
    a_ramp_legal: assert property (params.ramp_sel <= SMPB_RAMP_REVERSE && params.accel_freq <= FRQ_MAX_EXT &&
        params.decel_freq <= FRQ_MAX_EXT) else $error("ramp parameter out of range");
    a_olim_flags: assert property (params.olim_regen_boost |-> params.olim_accel ##0 params.olim_enable)
        else $error("overload mode flags inconsistent");

    c_write_ack: cover property (wb_req.we && wb_rsp.ack);
    c_read_ack: cover property (!wb_req.we && wb_rsp.ack);
    c_refused: cover property (wb_rsp.err);
endmodule // smpb_bank_props

bind smpb_bank smpb_bank_props smpb_bank_props_i (.wb_req(wb_req), .wb_rsp(wb_rsp), .params(params),
    .sys_clk(sys_clk), .rst(rst));
`default_nettype wire

// >>> dv/smpb_wb_master.sv
// smpb_wb_master: classic wishbone master model that reads and writes parameter words
`default_nettype none
module smpb_wb_master (
    input  wire logic                   sys_clk,
    output var  smpb_pkg::smpb_wb_req_t wb_req,
    input  wire smpb_pkg::smpb_wb_rsp_t wb_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    import smpb_pkg::*;
    initial wb_req = '0;

    // waits without a bound of its own; only the bench watchdog ends a hang
    task automatic xfer(input logic we, input logic [31:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        @(posedge sys_clk);
        wb_req <= '{cyc: 1'h1, stb: 1'h1, we: we, sel: sel, adr: adr, dat: dat};
        do @(posedge sys_clk); while (wb_rsp.ack !== 1'h1 && wb_rsp.err !== 1'h1);
        // a released bus shows the inverse, so a stale request can never look valid
        wb_req <= '{cyc: 1'h0, stb: 1'h0, we: ~we, sel: ~sel, adr: ~adr, dat: ~dat};
    endtask

    task automatic wr_wide(input logic [15:0] hi_idx, input logic [31:0] val);
        xfer(1'h1, {14'h0, hi_idx, 2'h0}, {16'h0, val[31:16]}, 4'hF);
        xfer(1'h1, {14'h0, hi_idx + 16'h1, 2'h0}, {16'h0, val[15:0]}, 4'hF);
    endtask
endmodule // smpb_wb_master
`default_nettype wire

// >>> dv/smpb_bank_test.sv
// smpb_bank_test: self-checking bench for the second-motor parameter bank
`default_nettype none
module smpb_bank_test;
    timeunit 1ns;
    timeprecision 1ps;
    import smpb_pkg::*;

    logic         sys_clk   = 1'h0;
    logic         rst       = 1'h1;
    smpb_wb_req_t wb_req;
    smpb_wb_rsp_t wb_rsp;
    smpb_params_t params;
    int           bad_count = 0;
    int           checked   = 0;
    int           seed      = 42855;
    logic [33:0]  notes[$];
    logic [33:0]  note;
    logic [15:0]  shadow[logic [15:0]];
    localparam logic [15:0] RIDX [17] = '{IDX_SECOND_ACCEL_RAMP_HI, IDX_SECOND_ACCEL_RAMP_LO, IDX_SECOND_DECEL_RAMP_HI, IDX_SECOND_DECEL_RAMP_LO, IDX_RSW, IDX_AFRQ_HI,
        IDX_AFRQ_LO, IDX_DFRQ_HI, IDX_DFRQ_LO, IDX_THLV, IDX_THCV, IDX_OLMD, IDX_OLLV, IDX_OLDR, IDX_OLW2, IDX_MDSRC, IDX_MCAP};
    localparam logic [15:0] RVAL [17] = '{RST_TIME2[31:16], RST_TIME2[15:0], RST_TIME2[31:16], RST_TIME2[15:0], RST_ZERO,
        RST_FRQ[31:16], RST_FRQ[15:0], RST_FRQ[31:16], RST_FRQ[15:0], RST_THLV, RST_ZERO, RST_ZERO, RST_OLLV, RST_OLDR,
        RST_OLW2, RST_ZERO, RST_ZERO};
    localparam logic [15:0] PROBE [18] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'hF, 16'h10, 16'h63, 16'h64, 16'hC7,
        16'hC8, 16'h3E8, 16'h3E9, 16'h7D0, 16'h7D1, 16'h7530, 16'h7531, 16'hFFFF};

    always #2 sys_clk = ~sys_clk;

    smpb_bank smpb_bank_i (.sys_clk(sys_clk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp), .params(params));
    smpb_wb_master smpb_wb_master_i (.sys_clk(sys_clk), .wb_req(wb_req), .wb_rsp(wb_rsp));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic summarize();
        if (bad_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************
    // response monitor: each answer retires the oldest note
    // ****************************************
    always @(posedge sys_clk) begin
        if (wb_rsp.ack === 1'h1 || wb_rsp.err === 1'h1) begin
            note = (notes.size() > 0) ? notes.pop_front() : 34'h3_FFFF_FFFF;
            chk("err", {31'h0, note[32]}, {31'h0, wb_rsp.err});
            if (note[33]) begin
                chk("read data", note[31:0], wb_rsp.dat);
            end
        end
    end

    function automatic logic legal(input logic [15:0] idx, input logic [15:0] v);
        case (idx)
            IDX_RSW:   return v <= RSW_MAX;
            IDX_THLV:  return v >= THLV_MIN && v <= THLV_MAX;
            IDX_THCV:  return v <= THCV_MAX;
            IDX_OLMD:  return v <= OLMD_MAX;
            IDX_OLLV:  return v >= OLLV_MIN && v <= OLLV_MAX;
            IDX_OLDR:  return v >= OLDR_MIN && v <= OLDR_MAX;
            IDX_OLW2:  return v <= OLW2_MAX;
            IDX_MDSRC: return v == MDSRC_STD || v == MDSRC_AUTO;
            default:   return v <= MCAP_MAX;
        endcase
    endfunction

    // for reads val is the expected data
    task automatic acc(input logic we, input logic [15:0] idx, input logic [15:0] val, input logic e);
        notes.push_back({~we, e, 16'h0, (we ? 16'h0 : val)});
        smpb_wb_master_i.xfer(we, {14'h0, idx, 2'h0}, {16'h0, val}, 4'hF);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] v);
        logic ok;
        ok = legal(idx, v);
        acc(1'h1, idx, v, ~ok);
        if (ok) shadow[idx] = v;
        acc(1'h0, idx, shadow[idx], 1'h0);
    endtask

    task automatic wr32(input logic [15:0] hi, input logic [31:0] v, input logic ok);
        notes.push_back(34'h0);
        notes.push_back({1'h0, ~ok, 32'h0});
        smpb_wb_master_i.wr_wide(hi, v);
        if (ok) shadow[hi] = v[31:16];
        if (ok) shadow[hi + 16'h1] = v[15:0];
        acc(1'h0, hi, shadow[hi], 1'h0);
        acc(1'h0, hi + 16'h1, shadow[hi + 16'h1], 1'h0);
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'h0;
        foreach (RIDX[i]) shadow[RIDX[i]] = RVAL[i];
        foreach (RIDX[i]) acc(1'h0, RIDX[i], RVAL[i], 1'h0);
        for (int r = 9; r < 17; r++) begin
            foreach (PROBE[p]) wr(RIDX[r], PROBE[p]);
            wr(RIDX[r], 16'($random(seed)));
        end
        foreach (PROBE[p]) wr(IDX_RSW, PROBE[p]);
        for (int m = 0; m < 4; m++) begin
            wr(IDX_OLMD, 16'(m));
            repeat (3) @(posedge sys_clk);
            chk("olim flags", {29'h0, m != 0, m == 1 || m == 3, m == 3},
                {29'h0, params.olim_enable, params.olim_accel, params.olim_regen_boost});
        end
        chk("params", {shadow[IDX_THLV], shadow[IDX_OLW2]}, {params.thermal_level, params.warn_level});
        chk("capacity", {28'h0, shadow[IDX_MCAP][3:0]}, {28'h0, params.capacity});
        chk("modes", {27'h0, shadow[IDX_RSW][1:0], shadow[IDX_THCV][1:0], shadow[IDX_MDSRC] == MDSRC_AUTO},
            {27'h0, params.ramp_sel, params.thermal_curve, params.data_autotuned});
        chk("olim levels", {shadow[IDX_OLLV], shadow[IDX_OLDR]}, {params.olim_level, params.olim_decel});
        chk("decel time", RST_TIME2, params.decel_time);
        wr32(IDX_SECOND_ACCEL_RAMP_HI, 32'h0, 1'h0);
        wr32(IDX_SECOND_ACCEL_RAMP_HI, TIME2_MAX, 1'h1);
        wr32(IDX_SECOND_ACCEL_RAMP_HI, TIME2_MAX + 32'h1, 1'h0);
        foreach (RIDX[i]) if (RIDX[i] == IDX_AFRQ_HI || RIDX[i] == IDX_DFRQ_HI) begin
            wr32(RIDX[i], FRQ_MAX_STD, 1'h1);
            wr32(RIDX[i], FRQ_MAX_STD + 32'h1, 1'h0);
            acc(1'h1, IDX_CTRL, 16'h1, 1'h0);
            wr32(RIDX[i], FRQ_MAX_EXT, 1'h1);
            wr32(RIDX[i], FRQ_MAX_EXT + 32'h1, 1'h0);
            acc(1'h1, IDX_CTRL, 16'h0, 1'h0);
        end
        repeat (3) @(posedge sys_clk);
        chk("freqs", params.accel_freq ^ params.decel_freq ^ params.accel_time, FRQ_MAX_EXT ^ FRQ_MAX_EXT ^ TIME2_MAX);
        acc(1'h1, IDX_AFRQ_LO, 16'h1, 1'h1);
        acc(1'h0, IDX_AFRQ_LO, shadow[IDX_AFRQ_LO], 1'h0);
        notes.push_back(34'h0);
        smpb_wb_master_i.xfer(1'h1, {14'h0, IDX_SECOND_ACCEL_RAMP_HI, 2'h0}, 32'h0, 4'hF);
        acc(1'h0, IDX_STAT, 16'h5, 1'h0);
        acc(1'h1, IDX_AFRQ_LO, 16'h1, 1'h1);
        acc(1'h0, IDX_AFRQ_LO, shadow[IDX_AFRQ_LO], 1'h0);
        notes.push_back({2'h1, 32'h0});
        smpb_wb_master_i.xfer(1'h1, {14'h0, IDX_THLV, 2'h0}, 32'h1F4, 4'h1);
        acc(1'h1, IDX_STAT, 16'h3, 1'h0);
        foreach (PROBE[p]) acc(PROBE[p][0], 16'h2278 + (PROBE[p] >> 1), 16'h0, 1'h1);
        notes.push_back({2'h1, 32'h0});
        smpb_wb_master_i.xfer(1'h1, {14'h1, IDX_THLV, 2'h0}, 32'h1F4, 4'hF);
        acc(1'h0, IDX_STAT, 16'h2, 1'h0);
        acc(1'h0, IDX_THLV, shadow[IDX_THLV], 1'h0);
        repeat (3) @(posedge sys_clk);
        chk("notes left", 32'h0, notes.size());
        summarize();
    end

    initial begin
        repeat (40000) @(posedge sys_clk);
        bad_count++;
        summarize();
    end
endmodule // smpb_bank_test
`default_nettype wire
